//--- logic/apb_reg_slave.sv
/*
  Holds a zero wait state APB slave front end that turns transfers into write and read strobes.
  Assumes a master following the APB setup and access phases.
*/
`timescale 1ns/1ps
module apb_reg_slave
  import pin_irq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input pin_irq_pkg::apb_req_type apbReq,
  input wire logic [31:0] readWord,
  input wire logic readHit,
  output logic writeStrobe,
  output logic readStrobe,
  output pin_irq_pkg::apb_rsp_type apbRsp
);
  import pin_irq_pkg::*;

  typedef struct packed {
    logic done;
    apb_rsp_type rsp;
  } slave_state_type;

  slave_state_type state_ff;
  slave_state_type nxt_state;
  logic access;

  // answer in access cycle via registered data prepared at setup
  assign access = apbReq.psel & apbReq.penable & ~state_ff.done;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.done = 1'b0;
    nxt_state.rsp.pready = 1'b0;
    nxt_state.rsp.pslverr = 1'b0;
    if (apbReq.psel & ~apbReq.penable) begin
      nxt_state.rsp.pready = 1'b1;
      nxt_state.rsp.pslverr = ~readHit;
      nxt_state.rsp.prdata = apbReq.pwrite ? 32'h0000_0000 : readWord;
    end
    if (access) begin
      nxt_state.done = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign writeStrobe = access & apbReq.pwrite & readHit;
  assign readStrobe = access & ~apbReq.pwrite & readHit;
  assign apbRsp = state_ff.rsp;
endmodule

//--- logic/external_pin_interrupt.sv
/*
  Holds the external pin interrupt unit: request latch, sensitivity select, mask,
  software acknowledge, event status with mask and an APB register port.
  Assumes a CPU that pulses a vector fetch acknowledge and an active low request pin.
*/
`timescale 1ns/1ps
`include "pin_irq_map.svh"
module external_pin_interrupt
  import pin_irq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic requestPinN,
  input wire logic vectorFetchAck,
  input wire logic breakState,
  output logic cpuRequest,
  output logic eventIrq
);
  import pin_irq_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic edgeLatch;
    logic requestLatch;
    sense_type sense;
    logic requestMask;
    logic breakClearEnable;
    logic [`EVT_COUNT-1:0] evtStatus;
    logic [`EVT_COUNT-1:0] evtMask;
    logic [`EVT_COUNT-1:0] evtRead;
    logic cpuRequest;
    logic eventIrq;
  } unit_state_type;

  unit_state_type state_ff;
  unit_state_type nxt_state;

  apb_req_type apbReq;
  apb_rsp_type apbRsp;
  pin_event_type pinEvent;
  logic writeStrobe;
  logic readStrobe;
  logic readHit;
  logic [31:0] readWord;
  logic softAck;
  logic ackSeen;
  logic setLatch;
  logic clearLatch;

  assign apbReq.psel = psel;
  assign apbReq.penable = penable;
  assign apbReq.pwrite = pwrite;
  assign apbReq.paddr = paddr;
  assign apbReq.pwdata = pwdata;

  // ----------------------------------------
  // pin front end and bus slave
  // ----------------------------------------
  pin_edge_sync u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .requestPinN(requestPinN),
    .pinEvent(pinEvent)
  );

  apb_reg_slave u_slave (
    .ref_clk(ref_clk),
    .reset(reset),
    .apbReq(apbReq),
    .readWord(readWord),
    .readHit(readHit),
    .writeStrobe(writeStrobe),
    .readStrobe(readStrobe),
    .apbRsp(apbRsp)
  );

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  always_comb begin
    readWord = `RESET_WORD;
    readHit = 1'b1;
    unique case (paddr)
      `ADDR_STATUS_CONTROL: begin
        readWord[`BIT_SENSE_SELECT] = state_ff.sense == SENSE_EDGE_LEVEL;
        readWord[`BIT_MASK] = state_ff.requestMask;
        readWord[`BIT_ACK] = 1'b0;
        readWord[`BIT_PENDING] = state_ff.requestLatch;
        readWord[`BIT_PIN_LEVEL] = pinEvent.pinLevel;
      end
      `ADDR_IRQ_STATUS: begin
        readWord[`EVT_COUNT-1:0] = state_ff.evtStatus;
      end
      `ADDR_IRQ_MASK: begin
        readWord[`EVT_COUNT-1:0] = state_ff.evtMask;
      end
      `ADDR_BREAK_CTRL: begin
        readWord[`BIT_BREAK_CLEAR_EN] = state_ff.breakClearEnable;
      end
      default: begin
        readHit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // latch control
  // ----------------------------------------
  // ack is a strobe only; nothing stores it, so it cannot read back
  assign softAck = writeStrobe && paddr == `ADDR_STATUS_CONTROL && pwdata[`BIT_ACK]
                   && !(breakState && !state_ff.breakClearEnable);
  assign ackSeen = softAck | vectorFetchAck;

  assign setLatch = pinEvent.fallingEdge;
  assign clearLatch = ackSeen;

  always_comb begin
    nxt_state = state_ff;
    // set wins over a same cycle acknowledge
    if (setLatch) begin
      nxt_state.edgeLatch = 1'b1;
    end else if (clearLatch) begin
      nxt_state.edgeLatch = 1'b0;
    end
    if (writeStrobe && paddr == `ADDR_STATUS_CONTROL) begin
      nxt_state.sense = pwdata[`BIT_SENSE_SELECT] ? SENSE_EDGE_LEVEL : SENSE_EDGE;
      nxt_state.requestMask = pwdata[`BIT_MASK];
    end
    if (writeStrobe && paddr == `ADDR_IRQ_MASK) begin
      nxt_state.evtMask = pwdata[`EVT_COUNT-1:0];
    end
    if (writeStrobe && paddr == `ADDR_BREAK_CTRL) begin
      nxt_state.breakClearEnable = pwdata[`BIT_BREAK_CLEAR_EN];
    end
    // in edge-level mode a low pin keeps the request pending, whatever the order of ack and release
    nxt_state.requestLatch = nxt_state.edgeLatch
                             | ((nxt_state.sense == SENSE_EDGE_LEVEL) & ~pinEvent.pinLevel);
    // remember what the read reports at setup; events after setup must survive
    if (psel && !penable && !pwrite && paddr == `ADDR_IRQ_STATUS) begin
      nxt_state.evtRead = state_ff.evtStatus;
    end
    // event status: read clears what it reported, new event wins
    if (readStrobe && paddr == `ADDR_IRQ_STATUS) begin
      nxt_state.evtStatus = state_ff.evtStatus & ~state_ff.evtRead;
    end
    if (~state_ff.requestLatch & nxt_state.requestLatch) begin
      nxt_state.evtStatus[`EVT_LATCH_SET] = 1'b1;
    end
    if (state_ff.requestLatch & ~nxt_state.requestLatch) begin
      nxt_state.evtStatus[`EVT_LATCH_CLEAR] = 1'b1;
    end
    nxt_state.cpuRequest = nxt_state.requestLatch & ~nxt_state.requestMask;
    nxt_state.eventIrq = |(nxt_state.evtStatus & nxt_state.evtMask);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign prdata = apbRsp.prdata;
  assign pready = apbRsp.pready;
  assign pslverr = apbRsp.pslverr;
  assign cpuRequest = state_ff.cpuRequest;
  assign eventIrq = state_ff.eventIrq;
endmodule

//--- logic/pin_edge_sync.sv
/*
  Holds the pin synchroniser and falling edge detector.
  Assumes an asynchronous pin that idles high and a single bus clock.
*/
`timescale 1ns/1ps
`include "pin_irq_map.svh"
module pin_edge_sync
  import pin_irq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic requestPinN,
  output pin_irq_pkg::pin_event_type pinEvent
);
  import pin_irq_pkg::*;

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic [`SYNC_SETTLE-1:0] settle;
  } sync_state_type;

  sync_state_type state_ff;
  sync_state_type nxt_state;

  // first stage feeds only the second stage
  always_comb begin
    nxt_state.meta = requestPinN;
    nxt_state.sync = state_ff.meta;
    nxt_state.last = state_ff.sync;
    nxt_state.settle = {state_ff.settle[`SYNC_SETTLE-2:0], 1'b1};
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_ff.meta <= `PIN_IDLE;
      state_ff.sync <= `PIN_IDLE;
      state_ff.last <= `PIN_IDLE;
      state_ff.settle <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pinEvent.pinLevel = state_ff.sync;
  // no edge until the chain holds real samples, so a pin held low through reset
  // cannot latch; limitation: a fall in the first cycles after reset is missed
  assign pinEvent.fallingEdge = state_ff.settle[`SYNC_SETTLE-1] & state_ff.last & ~state_ff.sync;
endmodule

//--- logic/pin_irq_map.svh
/*
  Holds register offsets, field positions, reset values and other constants of the pin interrupt unit.
  Assumes inclusion by the package and by every design file that needs a name from it.
*/
`ifndef PIN_IRQ_MAP_SVH
`define PIN_IRQ_MAP_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define ADDR_STATUS_CONTROL 12'h000
`define ADDR_IRQ_STATUS 12'h004
`define ADDR_IRQ_MASK 12'h008
`define ADDR_BREAK_CTRL 12'h00C

// ----------------------------------------
// status/control field positions
// ----------------------------------------
`define BIT_SENSE_SELECT 0
`define BIT_MASK 1
`define BIT_ACK 2
`define BIT_PENDING 3
`define BIT_PIN_LEVEL 4

// ----------------------------------------
// event status bits
// ----------------------------------------
`define EVT_LATCH_SET 0
`define EVT_LATCH_CLEAR 1
`define EVT_COUNT 2

// ----------------------------------------
// break control field, reset values and synchroniser settle depth
// ----------------------------------------
`define BIT_BREAK_CLEAR_EN 0
`define RESET_WORD 32'h0000_0000
`define RESET_EVT 2'h0
`define PIN_IDLE 1'b1
`define SYNC_SETTLE 3

`endif

//--- logic/pin_irq_pkg.sv
/*
  Holds the types of the pin interrupt unit.
  Assumes the constant header is on the include path.
*/
package pin_irq_pkg;
  `include "pin_irq_map.svh"

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;

  typedef enum logic {
    SENSE_EDGE,
    SENSE_EDGE_LEVEL
  } sense_type;

  typedef struct packed {
    logic pinLevel;
    logic fallingEdge;
  } pin_event_type;
endpackage

//--- tb/external_pin_interrupt_assertions.sv
/*
  Port checker for the pin interrupt unit.
  Assumes binding to external_pin_interrupt.
*/
`timescale 1ns/1ps
module external_pin_interrupt_assertions (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic requestPinN,
  input wire logic vectorFetchAck,
  input wire logic breakState,
  input wire logic cpuRequest,
  input wire logic eventIrq
);
  logic [2:0] ctlFf;
  logic xfer;
  logic ackWr;
  assign xfer = psel && penable && pready;
  assign ackWr = xfer && pwrite && paddr == 12'h000 && pwdata[2];
  // shadow of mode, mask and break clear enable
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctlFf <= 3'h0;
    end else if (xfer && pwrite && paddr == 12'h000) begin
      ctlFf[1:0] <= pwdata[1:0];
    end else if (xfer && pwrite && paddr == 12'h00C) begin
      ctlFf[2] <= pwdata[0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_unmapped_err: assert property (psel && !penable && paddr == 12'h010 |=> pslverr) else $error("no error");
  a_fall_sets: assert property (!ctlFf[1] && $fell(requestPinN) ##1 !requestPinN [*2] |-> ##[0:2] cpuRequest)
    else $error("fall not latched");
  a_vector_clears: assert property (requestPinN [*4] ##0 vectorFetchAck |=> !cpuRequest)
    else $error("vector ack kept request");
  a_soft_ack_clears: assert property (requestPinN [*4] ##0 ackWr && (!breakState || ctlFf[2]) |=> !cpuRequest)
    else $error("ack kept request");
  a_break_keeps: assert property (breakState && !ctlFf[2] && ackWr && !pwdata[1] && pwdata[0] == ctlFf[0]
    && cpuRequest && !vectorFetchAck
    |=> cpuRequest) else $error("ack in break cleared");
  a_mask_holds: assert property (ctlFf[1] && $past(ctlFf[1]) |-> !cpuRequest) else $error("masked request seen");
  a_level_holds: assert property ((ctlFf[1:0] == 2'b01 && !requestPinN) [*5] |-> cpuRequest)
    else $error("low level not pending");
  a_reset_clears: assert property ($fell(reset) |-> !cpuRequest && !eventIrq) else $error("request after reset");
  a_ack_reads_zero: assert property (xfer && !pwrite && paddr == 12'h000 |-> !prdata[2]) else $error("ack reads one");
  c_soft_ack: cover property (ackWr && cpuRequest);
  c_vector: cover property (vectorFetchAck && cpuRequest);
  c_event: cover property (eventIrq);
endmodule

bind external_pin_interrupt external_pin_interrupt_assertions i_chk (.ref_clk, .reset, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .requestPinN, .vectorFetchAck, .breakState, .cpuRequest, .eventIrq);

//--- tb/external_pin_interrupt_tb_top.sv
/*
  Self-checking bench for the pin interrupt unit.
  Assumes the pin source model and a zero wait APB slave.
*/
`timescale 1ns/1ps
module external_pin_interrupt_tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, vectorFetchAck = 1'b0, breakState = 1'b0, holdLow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, requestPinN, cpuRequest, eventIrq, err;
  int err_total = 0;
  int checks_done = 0;
  always #20 ref_clk = !ref_clk;
  pin_source i_src (.ref_clk, .holdLow, .requestPinN);
  external_pin_interrupt i_dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .requestPinN, .vectorFetchAck, .breakState, .cpuRequest, .eventIrq);
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    while (!got && n < 20) begin
      @(posedge ref_clk);
      n++;
      got = pready === 1'b1;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(got, "no ready");
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string m);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd === e, m);
  endtask
  task automatic drive(input logic lo, input int n);
    @(posedge ref_clk);
    holdLow <= lo;
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // cpu side: a set global mask leaves the request unserved, else the vector is fetched
  task automatic vec(input logic globalMask);
    @(posedge ref_clk);
    vectorFetchAck <= !globalMask;
    @(posedge ref_clk);
    vectorFetchAck <= 1'b0;
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic t_reset;
    rdchk(12'h000, 32'h0000_0010, "idle status");
    rdchk(12'h004, 32'h0000_0000, "idle events");
    xfer(1'b0, 12'h010, 32'h0000_0000);
    chk(err === 1'b1 && rd === 32'h0000_0000, "unmapped");
  endtask
  task automatic t_edge;
    drive(1'b1, 2);
    drive(1'b0, 4);
    chk(cpuRequest === 1'b1, "edge latch");
    chk(eventIrq === 1'b0, "event masked");
    drive(1'b0, 4);
    chk(cpuRequest === 1'b1, "edge hold");
    rdchk(12'h000, 32'h0000_0018, "pending");
    vec(1'b1);
    drive(1'b0, 2);
    chk(cpuRequest === 1'b1, "global mask");
    vec(1'b0);
    drive(1'b0, 2);
    chk(cpuRequest === 1'b0, "vector clear");
    rdchk(12'h004, 32'h0000_0003, "events");
  endtask
  task automatic t_mask;
    xfer(1'b1, 12'h008, 32'h0000_0001);
    xfer(1'b1, 12'h000, 32'h0000_0002);
    drive(1'b1, 2);
    drive(1'b0, 5);
    chk(cpuRequest === 1'b0, "masked");
    chk(eventIrq === 1'b1, "event irq");
    rdchk(12'h000, 32'h0000_001A, "pending masked");
    xfer(1'b1, 12'h000, 32'h0000_0006);
    rdchk(12'h000, 32'h0000_0012, "soft ack");
    rdchk(12'h004, 32'h0000_0003, "ack events");
    drive(1'b0, 2);
    chk(eventIrq === 1'b0, "event cleared");
  endtask
  task automatic t_level;
    xfer(1'b1, 12'h000, 32'h0000_0001);
    drive(1'b1, 5);
    vec(1'b0);
    drive(1'b1, 2);
    chk(cpuRequest === 1'b1, "level held");
    drive(1'b0, 4);
    chk(cpuRequest === 1'b0, "ack then high");
    drive(1'b1, 5);
    drive(1'b0, 4);
    chk(cpuRequest === 1'b1, "high waits ack");
    xfer(1'b1, 12'h000, 32'h0000_0005);
    drive(1'b0, 2);
    chk(cpuRequest === 1'b0, "level clear");
    drive(1'b1, 4);
    @(posedge ref_clk);
    reset <= 1'b1;
    drive(1'b1, 2);
    @(posedge ref_clk);
    reset <= 1'b0;
    drive(1'b1, 5);
    chk(cpuRequest === 1'b0, "reset low pin");
    rdchk(12'h000, 32'h0000_0000, "mode cleared");
  endtask
  task automatic t_break;
    drive(1'b0, 4);
    @(posedge ref_clk);
    breakState <= 1'b1;
    drive(1'b1, 2);
    drive(1'b0, 4);
    xfer(1'b1, 12'h000, 32'h0000_0004);
    drive(1'b0, 1);
    chk(cpuRequest === 1'b1, "break keeps");
    xfer(1'b1, 12'h00C, 32'h0000_0001);
    xfer(1'b1, 12'h000, 32'h0000_0004);
    drive(1'b0, 2);
    chk(cpuRequest === 1'b0, "break clear");
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_edge();
    t_mask();
    t_level();
    t_break();
    test_done();
  end
  // whole run is under two hundred cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_total++;
    test_done();
  end
endmodule

//--- tb/pin_source.sv
/*
  Off-chip request source on the active-low pin.
  Assumes the bench steers holdLow in step with ref_clk.
*/
`timescale 1ns/1ps
module pin_source (
  input wire logic ref_clk,
  input wire logic holdLow,
  output logic requestPinN
);
  // released line idles high, as on a pulled-up pin
  always_ff @(posedge ref_clk) begin
    requestPinN <= !holdLow;
  end
endmodule
